/* File: inc/sfr_map_pkg.sv */
/*
 * constants for the register-space map select and page extension block.
 * assumes an 8-bit core issuing direct register accesses on one clock.
 */
package sfr_map_pkg;
    localparam logic [7:0] sfr_base_addr        = 8'h80;
    localparam logic [7:0] system_control_zero_addr = 8'h8f;
    localparam logic [7:0] ccu_page_addr        = 8'ha3;
    localparam logic [7:0] system_control_zero_reset = 8'h00;
    localparam logic [7:0] page_reg_reset       = 8'h00;
    localparam int         map_area_select_bit  = 0;
    localparam int         sysctl_keep_bit      = 2;
    localparam int         op_msb = 7;
    localparam int         op_lsb = 6;
    localparam int         slot_msb = 5;
    localparam int         slot_lsb = 4;
    localparam int         page_msb = 2;
    localparam int         page_lsb = 0;
    localparam int         page_w   = 3;
    localparam int         slot_cnt = 4;
    localparam logic [1:0] op_plain   = 2'h0;
    localparam logic [1:0] op_save    = 2'h2;
    localparam logic [1:0] op_restore = 2'h3;
endpackage

/* File: inc/page_bus_if.sv */
/*
 * carries one page-register write and the resulting page between the
 * top module and the page engine; single clock domain.
 */
`timescale 1ns/10ps
interface page_bus_if;
    logic       wr;
    logic [7:0] wdata;
    logic [2:0] page;
    modport ctl (output wr, output wdata, input page);
    modport eng (input wr, input wdata, output page);
endinterface

/* File: verilog/page_engine.sv */
/*
 * page register with four save slots, updated by single writes.
 * assumes writes arrive as one-cycle strobes on clk.
 */
`timescale 1ns/10ps
module page_engine
    import sfr_map_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    page_bus_if.eng   pb
);
    logic [page_w-1:0] page_r, page_nxt;
    logic [page_w-1:0] slot_r [slot_cnt];
    logic [page_w-1:0] slot_nxt [slot_cnt];
    logic [1:0]        op;
    logic [1:0]        sel;

    assign op  = pb.wdata[op_msb:op_lsb];
    assign sel = pb.wdata[slot_msb:slot_lsb];
    assign pb.page = page_r;

    always_comb begin
        page_nxt = page_r;
        slot_nxt = slot_r;
        if (pb.wr) begin
            case (op)
                op_save: begin
                    slot_nxt[sel] = page_r;
                    page_nxt = pb.wdata[page_msb:page_lsb];
                end
                op_restore: begin
                    page_nxt = slot_r[sel];
                end
                default: begin
                    page_nxt = pb.wdata[page_msb:page_lsb];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_r <= page_reg_reset[page_msb:page_lsb];
            for (int i = 0; i < slot_cnt; i++) begin
                slot_r[i] <= '0;
            end
        end else begin
            page_r <= page_nxt;
            slot_r <= slot_nxt;
        end
    end

    property p_save_slot;
        logic [1:0] s;
        logic [2:0] p;
        @(posedge clk) disable iff (!nrst)
        (pb.wr && op == op_save, s = sel, p = page_r)
            |=> slot_r[s] == p;
    endproperty
    a_save_slot: assert property (p_save_slot)
        else $error("save write did not store old page");

    property p_save_load;
        @(posedge clk) disable iff (!nrst)
        pb.wr && op == op_save |=> page_r == $past(pb.wdata[2:0]);
    endproperty
    a_save_load: assert property (p_save_load)
        else $error("save write did not load new page");

    property p_restore;
        logic [2:0] v;
        @(posedge clk) disable iff (!nrst)
        (pb.wr && op == op_restore, v = slot_r[sel]) |=> page_r == v;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore did not load slot");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        !pb.wr |=> $stable(page_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("page changed without write");
endmodule

/* File: verilog/sfr_map_and_page_extension.sv */
/*
 * map select and capture/compare page extension of the register space.
 * assumes the core presents direct address, data and one-cycle strobes.
 */
`timescale 1ns/10ps
module sfr_map_and_page_extension
    import sfr_map_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_hit,
    output logic            map_area_select,
    output logic      [2:0] ccu_page,
    output logic            ccu_sel,
    output logic            mapped_sel
);
    import sfr_map_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic       in_space;
    logic       sysctl_hit;
    logic       page_hit;
    logic       map_r, map_nxt;
    logic       keep_r, keep_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    page_bus_if pb ();

    // system control sits in both areas; page register in standard only
    assign in_space   = sfr_addr[7];
    assign sysctl_hit = in_space && sfr_addr == system_control_zero_addr;
    assign page_hit   = in_space && !map_r
                        && sfr_addr == ccu_page_addr;
    assign ccu_sel    = in_space && !map_r;
    assign mapped_sel = in_space && map_r;
    assign sfr_hit    = in_space && (sfr_wr || sfr_rd);
    assign map_area_select = map_r;
    assign ccu_page   = pb.page;

    assign pb.wr    = sfr_wr && page_hit;
    assign pb.wdata = sfr_wdata;

    page_engine u_page (
        .clk  (clk),
        .nrst (nrst),
        .pb   (pb)
    );

    ////////////////////////////////////////////////////////////////////////
    // system control register and read data

    always_comb begin
        map_nxt   = map_r;
        keep_nxt  = keep_r;
        rdata_nxt = rdata_r;
        if (sfr_wr && sysctl_hit) begin
            map_nxt  = sfr_wdata[map_area_select_bit];
            keep_nxt = sfr_wdata[sysctl_keep_bit];
        end
        if (sfr_rd) begin
            if (sysctl_hit) begin
                rdata_nxt = {5'h00, keep_r, 1'b0, map_r};
            end else if (page_hit) begin
                rdata_nxt = {5'h00, pb.page};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            map_r   <= system_control_zero_reset[map_area_select_bit];
            keep_r  <= system_control_zero_reset[sysctl_keep_bit];
            rdata_r <= 8'h00;
        end else begin
            map_r   <= map_nxt;
            keep_r  <= keep_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_sysctl_wr;
        sfr_wr && sfr_addr == 8'h8f;
    endsequence

    sequence s_sysctl_rd;
        sfr_rd && !sfr_wr && sfr_addr == 8'h8f;
    endsequence

    // page register write that the standard area accepts
    sequence s_page_wr;
        sfr_wr && !map_area_select && sfr_addr == 8'ha3;
    endsequence

    property p_map_set;
        @(posedge clk) disable iff (!nrst)
        s_sysctl_wr |=> map_area_select == $past(sfr_wdata[0]);
    endproperty
    a_map_set: assert property (p_map_set)
        else $error("map select not taken from bit 0");

    property p_sysctl_read;
        @(posedge clk) disable iff (!nrst)
        sfr_rd && sfr_addr == 8'h8f |=> sfr_rdata[7:3] == 5'h00
            && sfr_rdata[1] == 1'b0
            && sfr_rdata[0] == $past(map_area_select);
    endproperty
    a_sysctl_read: assert property (p_sysctl_read)
        else $error("system control read shows reserved bits");

    property p_keep_bit;
        @(posedge clk) disable iff (!nrst)
        s_sysctl_wr ##1 !(sfr_wr && sfr_addr == 8'h8f) ##1 s_sysctl_rd
            |=> sfr_rdata[2] == $past(sfr_wdata[2], 3);
    endproperty
    a_keep_bit: assert property (p_keep_bit)
        else $error("bit 2 does not read back");

    property p_low_ignored;
        @(posedge clk) disable iff (!nrst)
        sfr_addr < 8'h80 |-> !sfr_hit && !ccu_sel && !mapped_sel;
    endproperty
    a_low_ignored: assert property (p_low_ignored)
        else $error("access below 80h decoded");

    property p_page_std_only;
        @(posedge clk) disable iff (!nrst)
        map_area_select && sfr_wr && sfr_addr == 8'ha3 |=> $stable(ccu_page);
    endproperty
    a_page_std_only: assert property (p_page_std_only)
        else $error("page register responded in mapped area");

    property p_page_read;
        @(posedge clk) disable iff (!nrst)
        sfr_rd && !sfr_wr && !map_area_select && sfr_addr == 8'ha3
            |=> sfr_rdata == {5'h00, ccu_page};
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page read shows op or slot bits");

    property p_areas_exclusive;
        @(posedge clk) disable iff (!nrst)
        !(ccu_sel && mapped_sel);
    endproperty
    a_areas_exclusive: assert property (p_areas_exclusive)
        else $error("both areas selected");

    property p_plain_write;
        @(posedge clk) disable iff (!nrst)
        sfr_wr && !map_area_select && sfr_addr == 8'ha3
            && sfr_wdata[7:6] == 2'h0
            |=> ccu_page == $past(sfr_wdata[2:0]);
    endproperty
    a_plain_write: assert property (p_plain_write)
        else $error("plain page write not loaded");

    // the second plain code must load the page as well
    property p_plain_alt;
        @(posedge clk) disable iff (!nrst)
        s_page_wr && sfr_wdata[7:6] == 2'h1
            |=> ccu_page == $past(sfr_wdata[2:0]);
    endproperty
    a_plain_alt: assert property (p_plain_alt)
        else $error("alternate plain page write not loaded");

    property p_save_top;
        @(posedge clk) disable iff (!nrst)
        s_page_wr && sfr_wdata[7:6] == 2'h2
            |=> ccu_page == $past(sfr_wdata[2:0]);
    endproperty
    a_save_top: assert property (p_save_top)
        else $error("save write did not show new page");

    property p_hit_decode;
        @(posedge clk) disable iff (!nrst)
        (sfr_wr || sfr_rd) && sfr_addr >= 8'h80 |-> sfr_hit;
    endproperty
    a_hit_decode: assert property (p_hit_decode)
        else $error("access in register space not decoded");

    property p_map_hold;
        @(posedge clk) disable iff (!nrst)
        !(sfr_wr && sfr_addr == 8'h8f) |=> $stable(map_area_select);
    endproperty
    a_map_hold: assert property (p_map_hold)
        else $error("map select changed without write");

    property p_mapped_sel;
        @(posedge clk) disable iff (!nrst)
        sfr_addr >= 8'h80 |-> mapped_sel == map_area_select;
    endproperty
    a_mapped_sel: assert property (p_mapped_sel)
        else $error("mapped area select does not follow map bit");

    property p_ccu_sel;
        @(posedge clk) disable iff (!nrst)
        sfr_addr >= 8'h80 |-> ccu_sel == !map_area_select;
    endproperty
    a_ccu_sel: assert property (p_ccu_sel)
        else $error("standard area select does not follow map bit");

    // page register hidden while the mapped area is chosen
    property p_mapped_page_read;
        @(posedge clk) disable iff (!nrst)
        sfr_rd && map_area_select && sfr_addr == 8'ha3
            |=> sfr_rdata == 8'h00;
    endproperty
    a_mapped_page_read: assert property (p_mapped_page_read)
        else $error("page register read in mapped area");

    // only the two decoded registers return data
    property p_other_read;
        @(posedge clk) disable iff (!nrst)
        sfr_rd && sfr_addr != 8'h8f && sfr_addr != 8'ha3
            |=> sfr_rdata == 8'h00;
    endproperty
    a_other_read: assert property (p_other_read)
        else $error("undecoded address returned data");
endmodule

/* File: dv/cpu_core_model.sv */
/*
 * model of the cpu core issuing direct register reads and writes.
 * assumes the block samples one-cycle strobes on the rising clk edge.
 */
`timescale 1ns/10ps
module cpu_core_model (
    input  wire logic       clk,
    output logic      [7:0] sfr_addr,
    output logic      [7:0] sfr_wdata,
    output logic            sfr_wr,
    output logic            sfr_rd,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       sfr_hit
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end
    // one write strobe; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        #1 h = sfr_hit;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        d = sfr_rdata;
    endtask
endmodule

/* File: dv/tb_top.sv */
/*
 * self-checking bench for the map select and page extension block.
 * assumes the cpu model drives all bus inputs at the falling edge.
 */
`timescale 1ns/10ps
module tb_top;
    import sfr_map_pkg::*;
    logic       clk;
    logic       nrst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic       sfr_hit;
    logic       map_area_select;
    logic [2:0] ccu_page;
    logic       ccu_sel;
    logic       mapped_sel;
    logic [1:0] sel_seen;
    int         n_errors = 0;
    int         compares = 0;

    sfr_map_and_page_extension uut (.clk(clk), .nrst(nrst),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .map_area_select(map_area_select), .ccu_page(ccu_page),
        .ccu_sel(ccu_sel), .mapped_sel(mapped_sel));
    cpu_core_model cpu (.clk(clk), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));

    // area selects seen while a read strobe is up
    always @(posedge clk) if (sfr_rd) sel_seen <= {ccu_sel, mapped_sel};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(logic [7:0] a, logic [7:0] e, logic eh);
        logic [7:0] d;
        logic       h;
        cpu.rd(a, d, h);
        chk("rdata", e, d);
        chk("hit", {7'h0, eh}, {7'h0, h});
    endtask
    task automatic pg(logic [2:0] e);
        chk("ccu_page", {5'h0, e}, {5'h0, ccu_page});
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk(system_control_zero_addr, 8'h00, 1'b1);
        rdchk(ccu_page_addr, 8'h00, 1'b1);
        pg(3'h0);
    endtask
    task automatic t_sysctl;
        cpu.wr(system_control_zero_addr, 8'hff);
        rdchk(system_control_zero_addr, 8'h05, 1'b1);
        chk("map", 8'h01, {7'h0, map_area_select});
        cpu.wr(system_control_zero_addr, 8'h04);
        rdchk(system_control_zero_addr, 8'h04, 1'b1);
        chk("map", 8'h00, {7'h0, map_area_select});
    endtask
    task automatic t_plain;
        cpu.wr(ccu_page_addr, 8'h0b);
        pg(3'h3);
        rdchk(ccu_page_addr, 8'h03, 1'b1);
        cpu.wr(ccu_page_addr, 8'h45);
        pg(3'h5);
    endtask
    task automatic t_slots;
        for (int s = 0; s < 4; s++) begin
            cpu.wr(ccu_page_addr, {op_plain, 2'(s), 1'b0, 3'(s)});
            cpu.wr(ccu_page_addr, {op_save, 2'(s), 1'b0, 3'(7-s)});
            pg(3'(7 - s));
        end
        for (int s = 0; s < 4; s++) begin
            cpu.wr(ccu_page_addr, {op_restore, 2'(s), 4'h7});
            pg(3'(s));
        end
    endtask
    task automatic t_map;
        cpu.wr(system_control_zero_addr, 8'h05);
        cpu.wr(ccu_page_addr, 8'h02);
        pg(3'h3);
        rdchk(ccu_page_addr, 8'h00, 1'b1);
        chk("sel", 8'h01, {6'h0, sel_seen});
        rdchk(system_control_zero_addr, 8'h05, 1'b1);
        cpu.wr(system_control_zero_addr, 8'h04);
        rdchk(ccu_page_addr, 8'h03, 1'b1);
        chk("sel", 8'h02, {6'h0, sel_seen});
    endtask
    task automatic t_decode;
        rdchk(8'h7f, 8'h00, 1'b0);
        rdchk(sfr_base_addr, 8'h00, 1'b1);
        rdchk(8'hff, 8'h00, 1'b1);
        rdchk(8'ha4, 8'h00, 1'b1);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_reset;
        t_sysctl;
        t_plain;
        t_slots;
        t_map;
        t_decode;
        end_sim;
    end
    initial begin
        #20000;
        n_errors++;
        end_sim;
    end
endmodule
